// [uhp_params.svh]
`ifndef UHP_PARAMS_SVH
`define UHP_PARAMS_SVH
// register byte offsets
`define UHP_OFS_CMD 12'h140
`define UHP_OFS_STS 12'h144
`define UHP_OFS_PORT 12'h184
`define UHP_OFS_MODE 12'h1a8
// port register fields
`define UHP_B_CCS 0
`define UHP_B_CSC 1
`define UHP_B_PE 2
`define UHP_B_PEC 3
`define UHP_B_OCA 4
`define UHP_B_OCC 5
`define UHP_B_FPR 6
`define UHP_B_SLEEP_REQUEST_BIT 7
`define UHP_B_PR 8
`define UHP_B_LS 10
`define UHP_B_PP 12
// mode register fields and reset
`define UHP_B_ROLE 0
`define UHP_B_ES 2
`define UHP_B_FIFO_STREAM_OFF 4
`define UHP_MODE_RST 32'h00000003
`define UHP_ROLE_HOST 2'h3
`define UHP_ROLE_IDLE 2'h0
// command and status fields
`define UHP_B_CMD_RST 1
`define UHP_B_PCD 2
// line states
`define UHP_LS_J 2'h2
`define UHP_LS_K 2'h1
// signalling times
`define UHP_CLK_MHZ 100
`define UHP_RST_MS 10
`define UHP_RSM_MS 20
`define UHP_RST_CYC (`UHP_RST_MS * 1000 * `UHP_CLK_MHZ)
`define UHP_RSM_CYC (`UHP_RSM_MS * 1000 * `UHP_CLK_MHZ)
`endif

// [uhp_pkg.sv]
package uhp_pkg;
	typedef enum logic [1:0] {
		UHP_SEQ_IDLE = 2'b00,
		UHP_SEQ_RESET = 2'b01,
		UHP_SEQ_RESUME = 2'b10
	} uhp_seq_e;
	typedef struct packed {
		logic pp;
		logic pr;
		logic sleep_request_bit;
		logic resume_drive_bit;
		logic overcurrent_change_flag;
		logic overcurrent_active_bit;
		logic enable_change_flag;
		logic pe;
		logic connect_change_flag;
		logic connect_present_bit;
	} uhp_port_s;
	typedef struct packed {
		logic stream_off;
		logic byte_order;
		logic [1:0] role;
		logic role_locked;
	} uhp_mode_s;
	typedef struct packed {
		logic drive_reset;
		logic drive_resume;
		logic data_block;
		logic [1:0] port_state;
		logic launch_ok;
	} uhp_pins_s;
endpackage : uhp_pkg

// [uhp_port.sv]
// Operation
// [R1] port reset bit starts bus reset; hardware clears it when done
// [R2] power off holds reset, sleep, resume, enable and connect bits at zero
// [R3] port state from enable and sleep: 0x disabled, 10 enabled, 11 suspended
// [R4] suspend takes effect after current transaction; bit shows it only then
// [R5] suspended port sets resume drive bit on J-to-K line transition
// [R6] remote wake also sets port change detect in main status
// [R7] sleep bit cleared whenever resume drive bit returns to zero
// [R8] software zero writes to sleep bit are ignored
// [R9] software must not request sleep while the link is disabled
// [R10] resume drive bit one drives full-speed K on the port
// [R11] hardware times resume and clears the bit; zero writes ignored
// [R12] over-current change set on any change of active; write one clears
// [R13] over-current active follows the supply fault input
// [R14] enable change set only on disconnect or EOF2 disable; write one clears
// [R15] enable set only by reset sequence; disabled by faults or software
// [R16] disabled port blocks data except reset; enable follows actual state
// [R17] connect change set on every connect change; write one clears
// [R18] role register at 1a8h, resets to 00000003h host
// [R19] stream off makes transmit FIFO fill completely before launch
// [R20] byte order select swaps buffer bytes only, default little-endian
// [R21] role field takes one write after reset; command reset re-arms it
// [R22] role encoding: 00 idle, 01 and 10 reserved, 11 host
// [R23] internal counter times reset and resume signalling
`timescale 1ns/1ps
`include "uhp_params.svh"
module uhp_port #(
	parameter bit HOST_ONLY = 1'b1,
	parameter int unsigned RST_CYCLES = `UHP_RST_CYC,
	parameter int unsigned RSM_CYCLES = `UHP_RSM_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// port line side
	input wire logic i_connect,
	input wire logic [1:0] i_line_state,
	input wire logic i_vbus_fault,
	input wire logic i_xact_busy,
	input wire logic i_eof2_fault,
	input wire logic i_port_fault,
	input wire logic i_txfifo_full,
	output uhp_pkg::uhp_pins_s o_pins,
	// mode outputs and buffer data path
	output logic o_fifo_stream_off,
	output logic [1:0] o_role,
	input wire logic [31:0] i_buf_data,
	output logic [31:0] o_buf_data
);
	// ==========================================================
	// decode helpers
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic [31:0] swap(input logic [31:0] w, input logic en);
		swap = en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction : swap

	localparam logic [20:0] RST_LAST = 21'(RST_CYCLES - 1);
	localparam logic [20:0] RSM_LAST = 21'(RSM_CYCLES - 1);
	localparam logic [1:0] ROLE_RST = HOST_ONLY ? `UHP_ROLE_HOST : `UHP_ROLE_IDLE;

	// ==========================================================
	// state
	uhp_pkg::uhp_port_s port_q, port_d;
	uhp_pkg::uhp_mode_s mode_q, mode_d;
	uhp_pkg::uhp_pins_s pins_d;
	uhp_pkg::uhp_seq_e seq_q, seq_d;
	logic [20:0] cnt_q, cnt_d;
	logic [1:0] ls_q;
	logic pend_q, pend_d, pcd_q, pcd_d;
	logic [31:0] rdata_d, buf_d;
	logic wr_port, wr_mode, wr_sts, soft_rst, wake;

	assign wr_port = i_wr && hit(i_addr, `UHP_OFS_PORT);
	assign wr_mode = i_wr && hit(i_addr, `UHP_OFS_MODE);
	assign wr_sts = i_wr && hit(i_addr, `UHP_OFS_STS);
	assign soft_rst = i_wr && hit(i_addr, `UHP_OFS_CMD) && i_wdata[`UHP_B_CMD_RST];
	// [R5] remote wake on J-to-K
	assign wake = port_q.sleep_request_bit && !port_q.resume_drive_bit && ls_q == `UHP_LS_J
		&& i_line_state == `UHP_LS_K;

	// ==========================================================
	// port next state; hardware events come after software so set wins
	always_comb begin
		port_d = port_q;
		seq_d = seq_q;
		cnt_d = cnt_q;
		pend_d = pend_q;
		pcd_d = pcd_q;
		if (wr_port) begin
			port_d.pp = i_wdata[`UHP_B_PP];
			// [R12] write one clears
			if (i_wdata[`UHP_B_OCC]) port_d.overcurrent_change_flag = 1'b0;
			// [R14] write one clears
			if (i_wdata[`UHP_B_PEC]) port_d.enable_change_flag = 1'b0;
			// [R17] write one clears
			if (i_wdata[`UHP_B_CSC]) port_d.connect_change_flag = 1'b0;
			// [R1] start bus reset
			if (i_wdata[`UHP_B_PR] && port_q.pp) begin
				port_d.pr = 1'b1;
				port_d.pe = 1'b0;
				port_d.resume_drive_bit = 1'b0; // reset aborts resume, else the bit would stick
				port_d.sleep_request_bit = 1'b0;
				pend_d = 1'b0;
				seq_d = uhp_pkg::UHP_SEQ_RESET;
				cnt_d = '0;
			end
			// [R8] only a one requests sleep
			if (i_wdata[`UHP_B_SLEEP_REQUEST_BIT] && port_q.pe && !port_q.sleep_request_bit) pend_d = 1'b1;
			// [R11] zero writes ignored; [R10] one starts resume
			if (i_wdata[`UHP_B_FPR] && !port_q.resume_drive_bit && seq_q == uhp_pkg::UHP_SEQ_IDLE) begin
				port_d.resume_drive_bit = 1'b1;
				seq_d = uhp_pkg::UHP_SEQ_RESUME;
				cnt_d = '0;
			end
			// [R15] software may only disable
			if (!i_wdata[`UHP_B_PE]) port_d.pe = 1'b0;
		end
		if (wr_sts && i_wdata[`UHP_B_PCD]) pcd_d = 1'b0;
		// [R13] follow the fault input
		port_d.overcurrent_active_bit = i_vbus_fault;
		// [R12] flag any change
		if (i_vbus_fault != port_q.overcurrent_active_bit) port_d.overcurrent_change_flag = 1'b1;
		// [R17] every connect change, even if set
		if (port_q.pp && i_connect != port_q.connect_present_bit) begin
			port_d.connect_present_bit = i_connect;
			port_d.connect_change_flag = 1'b1;
			pcd_d = 1'b1;
		end
		// [R14] disconnect or EOF2 disable flags change
		if (port_q.pe && ((port_q.connect_present_bit && !i_connect) || i_eof2_fault)) begin
			port_d.pe = 1'b0;
			port_d.enable_change_flag = 1'b1;
		end
		// [R15] other faults disable silently
		if (port_q.pe && i_port_fault) port_d.pe = 1'b0;
		// [R4] sleep lands only between transactions
		if (pend_q && !i_xact_busy) begin
			port_d.sleep_request_bit = port_d.pe;
			pend_d = 1'b0;
		end
		// [R5] [R6] remote wake
		if (wake) begin
			port_d.resume_drive_bit = 1'b1;
			pcd_d = 1'b1;
			seq_d = uhp_pkg::UHP_SEQ_RESUME;
			cnt_d = '0;
		end
		// [R23] signalling timer
		unique case (seq_q)
			uhp_pkg::UHP_SEQ_IDLE: begin
			end
			uhp_pkg::UHP_SEQ_RESET: begin
				cnt_d = cnt_q + 21'h1;
				// [R1] self clear; [R15] enable only here
				if (cnt_q == RST_LAST) begin
					port_d.pr = 1'b0;
					port_d.pe = port_d.connect_present_bit;
					seq_d = uhp_pkg::UHP_SEQ_IDLE;
				end
			end
			uhp_pkg::UHP_SEQ_RESUME: begin
				cnt_d = cnt_q + 21'h1;
				// [R11] [R7] end of resume clears both
				if (cnt_q == RSM_LAST) begin
					port_d.resume_drive_bit = 1'b0;
					port_d.sleep_request_bit = 1'b0;
					seq_d = uhp_pkg::UHP_SEQ_IDLE;
				end
			end
			default: seq_d = uhp_pkg::UHP_SEQ_IDLE;
		endcase
		// [R2] unpowered port reads zero except the over-current and line state bits
		if (!port_d.pp) begin
			{port_d.pr, port_d.sleep_request_bit, port_d.resume_drive_bit, port_d.enable_change_flag} = 4'h0;
			{port_d.pe, port_d.connect_change_flag, port_d.connect_present_bit} = 3'h0;
			pend_d = 1'b0;
			seq_d = uhp_pkg::UHP_SEQ_IDLE;
		end
	end

	// ==========================================================
	// mode next state and registered outputs
	always_comb begin
		mode_d = mode_q;
		if (wr_mode) begin
			mode_d.stream_off = i_wdata[`UHP_B_FIFO_STREAM_OFF];
			mode_d.byte_order = i_wdata[`UHP_B_ES];
			// [R21] role takes one write only
			if (!mode_q.role_locked) begin
				mode_d.role = i_wdata[`UHP_B_ROLE +: 2];
				mode_d.role_locked = 1'b1;
			end
		end
		// [R21] command reset re-arms the role
		if (soft_rst) begin
			mode_d = '0;
			mode_d.role = ROLE_RST;
		end
		// [R3] state encoding; [R10] K drive; [R16] block when not enabled
		pins_d.drive_reset = port_d.pr;
		pins_d.drive_resume = port_d.resume_drive_bit;
		pins_d.data_block = !port_d.pe || port_d.sleep_request_bit;
		pins_d.port_state = {port_d.pe, port_d.pe && port_d.sleep_request_bit};
		// [R19] hold launch until FIFO full
		pins_d.launch_ok = !mode_d.stream_off || i_txfifo_full;
		// [R20] swap only buffer data
		buf_d = swap(i_buf_data, mode_d.byte_order);
		rdata_d = 32'h0;
		if (i_rd && hit(i_addr, `UHP_OFS_PORT)) begin
			rdata_d[`UHP_B_PP] = port_q.pp;
			rdata_d[`UHP_B_LS +: 2] = i_line_state;
			rdata_d[`UHP_B_PR] = port_q.pr;
			rdata_d[`UHP_B_SLEEP_REQUEST_BIT] = port_q.sleep_request_bit;
			rdata_d[`UHP_B_FPR] = port_q.resume_drive_bit;
			rdata_d[`UHP_B_OCC] = port_q.overcurrent_change_flag;
			rdata_d[`UHP_B_OCA] = port_q.overcurrent_active_bit;
			rdata_d[`UHP_B_PEC] = port_q.enable_change_flag;
			rdata_d[`UHP_B_PE] = port_q.pe;
			rdata_d[`UHP_B_CSC] = port_q.connect_change_flag;
			rdata_d[`UHP_B_CCS] = port_q.connect_present_bit;
		end else if (i_rd && hit(i_addr, `UHP_OFS_MODE)) begin
			rdata_d[`UHP_B_FIFO_STREAM_OFF] = mode_q.stream_off;
			rdata_d[`UHP_B_ES] = mode_q.byte_order;
			rdata_d[`UHP_B_ROLE +: 2] = mode_q.role;
		end else if (i_rd && hit(i_addr, `UHP_OFS_STS)) begin
			rdata_d[`UHP_B_PCD] = pcd_q;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			port_q <= '0;
			seq_q <= uhp_pkg::UHP_SEQ_IDLE;
			cnt_q <= '0;
			ls_q <= 2'h0;
			pend_q <= 1'b0;
			pcd_q <= 1'b0;
			// [R18] [R22] host-only default 11
			mode_q <= '{stream_off: 1'b0, byte_order: 1'b0, role: ROLE_RST, role_locked: 1'b0};
			o_pins <= '0;
			o_rdata <= 32'h0;
			o_buf_data <= 32'h0;
			o_fifo_stream_off <= 1'b0;
			o_role <= ROLE_RST;
		end else begin
			port_q <= port_d;
			seq_q <= seq_d;
			cnt_q <= cnt_d;
			ls_q <= i_line_state;
			pend_q <= pend_d;
			pcd_q <= pcd_d;
			mode_q <= mode_d;
			o_pins <= pins_d;
			o_rdata <= rdata_d;
			o_buf_data <= buf_d;
			o_fifo_stream_off <= mode_d.stream_off;
			o_role <= mode_d.role;
		end
	end

	// ==========================================================
	// checks
	sequence s_jk;
		wake && port_q.pp;
	endsequence
	sequence s_rst_end;
		seq_q == uhp_pkg::UHP_SEQ_RESET && cnt_q == RST_LAST && port_q.pp;
	endsequence
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_reset_self_clear: assert property (s_rst_end |=> !port_q.pr) // [R1]
		else $error("port reset bit not cleared at end of reset");
	a_power_off_zero: assert property (!port_q.pp |-> !port_q.pe && !port_q.connect_present_bit
		&& !port_q.sleep_request_bit && !port_q.resume_drive_bit && !port_q.pr && !port_q.connect_change_flag) // [R2]
		else $error("unpowered port shows live bits");
	a_state_encode: assert property (1'b1 |=> o_pins.port_state
		== {port_q.pe, port_q.pe && port_q.sleep_request_bit}) // [R3]
		else $error("port state output wrong");
	a_sleep_waits: assert property (pend_q && i_xact_busy && !port_q.sleep_request_bit
		|=> !port_q.sleep_request_bit) // [R4]
		else $error("suspend during transaction");
	a_wake_sets: assert property (s_jk |=> port_q.resume_drive_bit && pcd_q) // [R5]
		else $error("remote wake missed");
	a_sleep_follows: assert property ($fell(port_q.resume_drive_bit) |-> !port_q.sleep_request_bit) // [R7]
		else $error("sleep bit left after resume");
	a_sleep_kept: assert property (port_q.sleep_request_bit && !port_q.resume_drive_bit && !wake
		|=> port_q.sleep_request_bit || !port_q.pe || !port_q.pp) // [R8]
		else $error("sleep bit cleared without resume");
	a_resume_timed: assert property (seq_q == uhp_pkg::UHP_SEQ_RESUME
		&& cnt_q == RSM_LAST |=> !port_q.resume_drive_bit) // [R11]
		else $error("resume bit not cleared at end");
	a_oc_change: assert property (i_vbus_fault != port_q.overcurrent_active_bit |=> port_q.overcurrent_change_flag
		&& port_q.overcurrent_active_bit == $past(i_vbus_fault)) // [R12]
		else $error("over-current change lost");
	a_enable_hw: assert property ($rose(port_q.pe) |-> $past(seq_q)
		== uhp_pkg::UHP_SEQ_RESET) // [R15]
		else $error("port enabled outside reset");
	a_conn_change: assert property (port_q.pp && i_connect != port_q.connect_present_bit
		|=> port_q.connect_change_flag && port_q.connect_present_bit == $past(i_connect)) // [R17]
		else $error("connect change lost");
	a_role_once: assert property (mode_q.role_locked && !soft_rst
		|=> $stable(mode_q.role)) // [R21]
		else $error("role changed twice");
	// [R1] reset drive follows bit
	a_reset_drive: assert property (1'b1 |=> o_pins.drive_reset == port_q.pr) // [R1]
		else $error("reset drive differs from port reset bit");

	// [R10] K drive follows bit
	a_resume_drive: assert property (1'b1 |=> o_pins.drive_resume == port_q.resume_drive_bit) // [R10]
		else $error("resume drive differs from resume bit");

	// [R16] block when disabled
	a_block_data: assert property (1'b1 |=> o_pins.data_block
		== (!port_q.pe || port_q.sleep_request_bit)) // [R16]
		else $error("data block wrong for port state");
	// [R19] launch held back
	a_launch_hold: assert property (mode_q.stream_off && !i_txfifo_full && !wr_mode
		&& !soft_rst |=> !o_pins.launch_ok) // [R19]
		else $error("packet launch allowed before fifo full");
	// [R3] disabled state code
	a_state_off: assert property (!port_q.pe |-> o_pins.port_state == 2'b00) // [R3]
		else $error("disabled port shows live state");

	// [R20] big-endian swap
	a_byte_swap: assert property (mode_q.byte_order && !wr_mode && !soft_rst |=> o_buf_data
		== {$past(i_buf_data[7:0]), $past(i_buf_data[15:8]), $past(i_buf_data[23:16]),
		$past(i_buf_data[31:24])}) // [R20]
		else $error("buffer bytes not swapped");
	// [R20] little-endian passthrough
	a_byte_plain: assert property (!mode_q.byte_order && !wr_mode && !soft_rst
		|=> o_buf_data == $past(i_buf_data)) // [R20]
		else $error("buffer bytes changed in little-endian mode");
	// [R21] command reset re-arms
	a_role_rearm: assert property (soft_rst |=> mode_q.role == ROLE_RST
		&& !mode_q.role_locked) // [R21]
		else $error("role not re-armed by command reset");
	// [R21] first write locks
	a_role_lock: assert property (wr_mode && !soft_rst |=> mode_q.role_locked) // [R21]
		else $error("role not locked after write");

	// [R13] active follows fault
	a_oc_follow: assert property (1'b1 |=> port_q.overcurrent_active_bit == $past(i_vbus_fault)) // [R13]
		else $error("over-current active does not follow fault");

	// [R14] change only on disable
	a_pec_cause: assert property ($rose(port_q.enable_change_flag) |-> $past(port_q.pe)) // [R14]
		else $error("enable change set without a disable");

	// [R11] resume bit held
	a_fpr_hold: assert property (port_q.resume_drive_bit && seq_q == uhp_pkg::UHP_SEQ_RESUME
		&& cnt_q != RSM_LAST && !wr_port |=> port_q.resume_drive_bit) // [R11]
		else $error("resume bit cleared before timer end");
	// [R23] reset bit held
	a_pr_hold: assert property (seq_q == uhp_pkg::UHP_SEQ_RESET && cnt_q != RST_LAST
		&& !wr_port |=> port_q.pr) // [R23]
		else $error("port reset bit cleared before timer end");
	// [R4] sleep via request only
	a_sleep_request_bit_cause: assert property ($rose(port_q.sleep_request_bit) |-> $past(pend_q)) // [R4]
		else $error("sleep bit set without pending request");

endmodule : uhp_port

// [uhp_dev_model.sv]
`timescale 1ns/1ps
`include "uhp_params.svh"
module uhp_dev_model (
	// bench commands
	input wire logic i_attach,
	input wire logic i_wake,
	// host line drive
	input wire uhp_pkg::uhp_pins_s i_pins,
	// device lines
	output logic o_connect,
	output logic [1:0] o_line_state
);
	// ==========
	// line levels at the port
	// detached lines fall to SE0 through the host pull-downs
	always_comb begin
		o_connect = i_attach;
		if (!i_attach || i_pins.drive_reset) begin
			o_line_state = 2'h0;
		end else if (i_wake || i_pins.drive_resume) begin
			o_line_state = `UHP_LS_K;
		end else begin
			o_line_state = `UHP_LS_J; // full-speed idle
		end
	end
endmodule : uhp_dev_model

// [uhp_port_bench.sv]
`timescale 1ns/1ps
module uhp_port_bench;
	// ==========
	// stimulus and observed signals
	logic i_clk = 1'h0;
	logic i_rst_b = 1'h0;
	logic [11:0] i_addr = 12'h000;
	logic [31:0] i_wdata = 32'h0;
	logic [31:0] i_buf_data = 32'h0;
	logic i_wr = 1'h0;
	logic i_rd = 1'h0;
	logic i_vbus_fault = 1'h0;
	logic i_xact_busy = 1'h0;
	logic i_eof2_fault = 1'h0;
	logic i_txfifo_full = 1'h0;
	logic attach = 1'h0;
	logic wake = 1'h0;
	logic i_connect;
	logic [1:0] i_line_state;
	logic [31:0] o_rdata;
	logic [31:0] o_buf_data;
	logic o_fifo_stream_off;
	logic [1:0] o_role;
	uhp_pkg::uhp_pins_s o_pins;
	int errors = 0;
	int n_compared = 0;
	// 100 MHz clock
	always #5 i_clk = ~i_clk;
	// short timers keep the run small
	uhp_port #(.RST_CYCLES(20), .RSM_CYCLES(30)) uhp_port_i (.i_clk(i_clk),
		.i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_connect(i_connect), .i_line_state(i_line_state),
		.i_vbus_fault(i_vbus_fault), .i_xact_busy(i_xact_busy), .i_eof2_fault(i_eof2_fault),
		.i_port_fault(1'h0), .i_txfifo_full(i_txfifo_full), .o_pins(o_pins),
		.o_fifo_stream_off(o_fifo_stream_off), .o_role(o_role), .i_buf_data(i_buf_data),
		.o_buf_data(o_buf_data));
	uhp_dev_model uhp_dev_model_i (.i_attach(attach), .i_wake(wake), .i_pins(o_pins),
		.o_connect(i_connect), .o_line_state(i_line_state));
	// ==========
	// bus tasks and checks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
		#1;
	endtask : wr
	// line state bits are masked by callers that do not own the lines
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		chk($sformatf("reg %h", a), exp & m, o_rdata & m);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// ==========
	// main sequence
	initial begin
		cyc(4);
		i_rst_b <= 1'h1;
		rd(12'h1a8, 32'h3, 32'h17);
		rd(12'h184, 32'h0, 32'h13ff);
		rd(12'h100, 32'h0, 32'hffffffff);
		wr(12'h184, 32'h1000);
		attach <= 1'h1;
		cyc(3);
		rd(12'h184, 32'h1003, 32'h13ff);
		wr(12'h184, 32'h1006);
		rd(12'h184, 32'h1001, 32'h13ff);
		wr(12'h184, 32'h1100);
		chk("drive_reset", 32'h1, o_pins.drive_reset);
		rd(12'h184, 32'h1101, 32'h13ff);
		cyc(25);
		rd(12'h184, 32'h1005, 32'h13ff);
		chk("port_state", 32'h2, o_pins.port_state);
		chk("data_block", 32'h0, o_pins.data_block);
		i_xact_busy <= 1'h1;
		wr(12'h184, 32'h1084);
		rd(12'h184, 32'h1005, 32'h13ff);
		i_xact_busy <= 1'h0;
		cyc(3);
		rd(12'h184, 32'h1085, 32'h13ff);
		chk("port_state", 32'h3, o_pins.port_state);
		chk("data_block", 32'h1, o_pins.data_block);
		wr(12'h184, 32'h1004);
		rd(12'h184, 32'h1085, 32'h13ff);
		wake <= 1'h1;
		cyc(3);
		wake <= 1'h0;
		rd(12'h184, 32'h10c5, 32'h13ff);
		rd(12'h144, 32'h4, 32'h4);
		chk("drive_resume", 32'h1, o_pins.drive_resume);
		wr(12'h184, 32'h1004);
		rd(12'h184, 32'h10c5, 32'h13ff);
		cyc(35);
		rd(12'h184, 32'h1005, 32'h13ff);
		i_vbus_fault <= 1'h1;
		cyc(3);
		rd(12'h184, 32'h1035, 32'h13ff);
		wr(12'h184, 32'h1024);
		rd(12'h184, 32'h1015, 32'h13ff);
		i_vbus_fault <= 1'h0;
		cyc(3);
		rd(12'h184, 32'h1025, 32'h13ff);
		wr(12'h184, 32'h1024);
		i_eof2_fault <= 1'h1;
		cyc(1);
		i_eof2_fault <= 1'h0;
		cyc(2);
		rd(12'h184, 32'h1009, 32'h13ff);
		chk("data_block", 32'h1, o_pins.data_block);
		attach <= 1'h0;
		cyc(3);
		rd(12'h184, 32'h100a, 32'h13ff);
		wr(12'h184, 32'h0);
		rd(12'h184, 32'h0, 32'h13ff);
		wr(12'h1a8, 32'h14);
		rd(12'h1a8, 32'h14, 32'h17);
		chk("role", 32'h0, o_role);
		chk("launch_ok", 32'h0, o_pins.launch_ok);
		i_txfifo_full <= 1'h1;
		cyc(2);
		chk("launch_ok", 32'h1, o_pins.launch_ok);
		wr(12'h1a8, 32'h07);
		rd(12'h1a8, 32'h04, 32'h17);
		chk("stream_off", 32'h0, o_fifo_stream_off);
		i_buf_data <= 32'h11223344;
		cyc(2);
		chk("buf_data", 32'h44332211, o_buf_data);
		wr(12'h140, 32'h2);
		rd(12'h1a8, 32'h3, 32'h17);
		wr(12'h1a8, 32'h0);
		rd(12'h1a8, 32'h0, 32'h17);
		test_done();
	end
endmodule : uhp_port_bench
